// >>> src/tev_event_report.sv
`timescale 1ns/1ps
module tev_event_report (
  input wire logic CLK,
  input wire logic RST,
  input wire tev_pkg::tev_learn_s LRN_EVT,
  input wire tev_pkg::tev_expire_s EXP_EVT,
  input wire logic [tev_pkg::STAT_N-1:0] STAT_MSB,
  input wire logic RD_STB,
  input wire logic WR_STB,
  input wire logic [tev_pkg::REG_AW-1:0] ADDR,
  input wire logic [7:0] WDATA,
  output logic [7:0] RDATA,
  output logic RD_VALID,
  output logic HOST_IRQ_OUT,
  output logic [tev_pkg::STAT_N-1:0] STAT_CLR
);
  localparam int FW = tev_pkg::FLAG_W;

  logic [FW-1:0] flags_reg, flags_next, set_v, clr_v;
  logic [FW-1:0] mask_reg, mask_next;
  tev_pkg::tev_entry_s lrn_reg, exp_reg;
  logic lrn_lock_reg, exp_lock_reg;
  logic lrn_rel, exp_rel, lrn_free, exp_free;
  logic [tev_pkg::STAT_N-1:0] msb_seen_reg, stat_hit;
  logic [7:0] rd_byte;

  function automatic int kind_bit(tev_pkg::tev_kind_e k, logic missed);
    int b;
    b = tev_pkg::B_FRESH;
    unique case (k)
      tev_pkg::LRN_MOVE: b = tev_pkg::B_MOVE;
      tev_pkg::LRN_LOCKED: b = tev_pkg::B_LOCKED;
      default: b = tev_pkg::B_FRESH;
    endcase
    return missed ? b + 1 : b;
  endfunction

  function automatic logic [7:0] mac_byte(logic [47:0] m, int k);
    return m[47-8*k -: 8];
  endfunction

  // A release in the same cycle as an event lets that event be captured
  assign lrn_rel = RD_STB && ADDR == tev_pkg::LRN_PORT_OFS;
  assign exp_rel = RD_STB && ADDR == tev_pkg::EXP_PORT_OFS;
  assign lrn_free = !lrn_lock_reg || lrn_rel;
  assign exp_free = !exp_lock_reg || exp_rel;

  always_comb begin
    set_v = '0;
    clr_v = '0;
    if (LRN_EVT.valid) begin
      set_v[kind_bit(LRN_EVT.kind, !lrn_free)] = 1'b1;
    end
    if (EXP_EVT.valid) begin
      if (exp_free) begin
        set_v[tev_pkg::B_EXPIRY] = 1'b1;
      end else begin
        set_v[tev_pkg::B_EXPIRY_MISS] = 1'b1;
      end
    end
    if (|(STAT_MSB & ~msb_seen_reg)) begin
      set_v[tev_pkg::B_STAT] = 1'b1;
    end
    if (WR_STB && ADDR == tev_pkg::INT_HI_OFS && WDATA[1]) begin
      set_v[tev_pkg::B_TEST] = 1'b1;
    end
    // Masked flags clear too; set beats clear
    if (RD_STB && ADDR == tev_pkg::INT_LO_OFS) begin
      clr_v[7:0] = 8'hFF;
    end
    if (RD_STB && ADDR == tev_pkg::INT_HI_OFS) begin
      clr_v[FW-1:8] = 2'h3;
    end
    flags_next = (flags_reg & ~clr_v) | set_v;
  end

  always_comb begin
    mask_next = mask_reg;
    if (WR_STB && ADDR == tev_pkg::MASK_LO_OFS) begin
      mask_next[7:0] = WDATA;
    end
    if (WR_STB && ADDR == tev_pkg::MASK_HI_OFS) begin
      mask_next[FW-1:8] = WDATA[1:0];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      flags_reg <= tev_pkg::FLAGS_RST;
      mask_reg <= tev_pkg::MASK_RST;
      HOST_IRQ_OUT <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      mask_reg <= mask_next;
      HOST_IRQ_OUT <= |(flags_next & mask_next);
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      lrn_lock_reg <= 1'b0;
      lrn_reg <= '0;
    end else if (LRN_EVT.valid && lrn_free) begin
      // Port field is the seen, new or attempted port per kind
      lrn_reg <= LRN_EVT.entry;
      lrn_lock_reg <= 1'b1;
    end else if (lrn_rel) begin
      lrn_lock_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      exp_lock_reg <= 1'b0;
      exp_reg <= '0;
    end else if (EXP_EVT.valid && exp_free) begin
      exp_reg <= EXP_EVT.entry;
      exp_lock_reg <= 1'b1;
    end else if (exp_rel) begin
      exp_lock_reg <= 1'b0;
    end
  end

  // Only counter bits above 23 matter; LSB-first reads are the host's job
  always_comb begin
    for (int i = 0; i < tev_pkg::STAT_N; i++) begin
      stat_hit[i] = RD_STB && ADDR == tev_pkg::STAT_BASE_OFS
        + 8'(4 * i) + 8'(tev_pkg::STAT_MSB_LANE);
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      msb_seen_reg <= '0;
      STAT_CLR <= '0;
    end else begin
      msb_seen_reg <= STAT_MSB;
      STAT_CLR <= stat_hit;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    unique case (ADDR)
      tev_pkg::INT_LO_OFS: rd_byte = flags_reg[7:0];
      tev_pkg::INT_HI_OFS: rd_byte = {6'h00, flags_reg[FW-1:8]};
      tev_pkg::MASK_LO_OFS: rd_byte = mask_reg[7:0];
      tev_pkg::MASK_HI_OFS: rd_byte = {6'h00, mask_reg[FW-1:8]};
      tev_pkg::LRN_WORD0_OFS: rd_byte = mac_byte(lrn_reg.mac, 0);
      tev_pkg::LRN_WORD0_OFS + 8'h01: rd_byte = mac_byte(lrn_reg.mac, 1);
      tev_pkg::LRN_WORD0_OFS + 8'h02: rd_byte = mac_byte(lrn_reg.mac, 2);
      tev_pkg::LRN_WORD0_OFS + 8'h03: rd_byte = mac_byte(lrn_reg.mac, 3);
      tev_pkg::LRN_WORD1_OFS: rd_byte = mac_byte(lrn_reg.mac, 4);
      tev_pkg::LRN_WORD1_OFS + 8'h01: rd_byte = mac_byte(lrn_reg.mac, 5);
      tev_pkg::LRN_PORT_OFS: rd_byte = lrn_reg.port;
      tev_pkg::EXP_WORD0_OFS: rd_byte = mac_byte(exp_reg.mac, 0);
      tev_pkg::EXP_WORD0_OFS + 8'h01: rd_byte = mac_byte(exp_reg.mac, 1);
      tev_pkg::EXP_WORD0_OFS + 8'h02: rd_byte = mac_byte(exp_reg.mac, 2);
      tev_pkg::EXP_WORD0_OFS + 8'h03: rd_byte = mac_byte(exp_reg.mac, 3);
      tev_pkg::EXP_WORD1_OFS: rd_byte = mac_byte(exp_reg.mac, 4);
      tev_pkg::EXP_WORD1_OFS + 8'h01: rd_byte = mac_byte(exp_reg.mac, 5);
      tev_pkg::EXP_PORT_OFS: rd_byte = exp_reg.port;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RDATA <= tev_pkg::RDATA_RST;
      RD_VALID <= 1'b0;
    end else begin
      RDATA <= RD_STB ? rd_byte : RDATA;
      RD_VALID <= RD_STB;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  property p_lrn_capture;
    LRN_EVT.valid && lrn_free |=> lrn_lock_reg
      && lrn_reg == $past(LRN_EVT.entry)
      && flags_reg[kind_bit($past(LRN_EVT.kind), 1'b0)];
  endproperty
  a_lrn_capture: assert property (p_lrn_capture)
    else $error("learned event not captured");

  property p_lrn_hold;
    lrn_lock_reg && !lrn_rel |=> lrn_lock_reg && $stable(lrn_reg);
  endproperty
  a_lrn_hold: assert property (p_lrn_hold)
    else $error("learned registers changed while locked");

  property p_lrn_missed;
    LRN_EVT.valid && !lrn_free |=>
      flags_reg[kind_bit($past(LRN_EVT.kind), 1'b1)];
  endproperty
  a_lrn_missed: assert property (p_lrn_missed)
    else $error("missed learning flag not set");

  property p_exp_capture;
    EXP_EVT.valid && exp_free |=> exp_lock_reg
      && exp_reg == $past(EXP_EVT.entry) && flags_reg[tev_pkg::B_EXPIRY];
  endproperty
  a_exp_capture: assert property (p_exp_capture)
    else $error("age-out not captured");

  property p_exp_missed;
    EXP_EVT.valid && !exp_free |=> $stable(exp_reg)
      && flags_reg[tev_pkg::B_EXPIRY_MISS];
  endproperty
  a_exp_missed: assert property (p_exp_missed)
    else $error("age-out while locked mishandled");

  property p_exp_release;
    exp_rel && !EXP_EVT.valid |=> !exp_lock_reg;
  endproperty
  a_exp_release: assert property (p_exp_release)
    else $error("expired lock not released");

  property p_stat_rise;
    |(STAT_MSB & ~$past(STAT_MSB)) |-> ##1 flags_reg[tev_pkg::B_STAT];
  endproperty
  a_stat_rise: assert property (p_stat_rise)
    else $error("statistic flag not raised");

  property p_stat_clr;
    RD_STB && ADDR == tev_pkg::STAT_BASE_OFS
      + 8'(tev_pkg::STAT_MSB_LANE) |=> STAT_CLR[0]
      ##1 !STAT_CLR[0] || $past(stat_hit[0]);
  endproperty
  a_stat_clr: assert property (p_stat_clr)
    else $error("counter clear pulse wrong");

  property p_int_clear;
    RD_STB && ADDR == tev_pkg::INT_LO_OFS && set_v[7:0] == 8'h00
      |=> flags_reg[7:0] == 8'h00;
  endproperty
  a_int_clear: assert property (p_int_clear)
    else $error("interrupt byte not cleared by read");

  property p_irq;
    HOST_IRQ_OUT == |(flags_reg & mask_reg);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output disagrees with flags");

  c_lrn_missed: cover property (LRN_EVT.valid && lrn_lock_reg && !lrn_rel);
  c_exp_relcap: cover property (exp_rel && EXP_EVT.valid);
  c_irq: cover property ($rose(HOST_IRQ_OUT) ##[1:20] $fell(HOST_IRQ_OUT));
  c_stat: cover property ($rose(flags_reg[tev_pkg::B_STAT]));
endmodule

// >>> src/tev_pkg.sv
package tev_pkg;
  localparam int REG_AW = 8;
  localparam int PORT_W = 8;
  localparam int MAC_W = 48;
  localparam int STAT_N = 8;
  localparam int FLAG_W = 10;

  localparam logic [7:0] INT_LO_OFS = 8'h20;
  localparam logic [7:0] INT_HI_OFS = 8'h21;
  localparam logic [7:0] MASK_LO_OFS = 8'h24;
  localparam logic [7:0] MASK_HI_OFS = 8'h25;
  localparam logic [7:0] LRN_WORD0_OFS = 8'h30;
  localparam logic [7:0] LRN_WORD1_OFS = 8'h34;
  localparam logic [7:0] LRN_PORT_OFS = 8'h37;
  localparam logic [7:0] EXP_WORD0_OFS = 8'h40;
  localparam logic [7:0] EXP_WORD1_OFS = 8'h44;
  localparam logic [7:0] EXP_PORT_OFS = 8'h46;
  localparam logic [7:0] STAT_BASE_OFS = 8'h50;
  localparam logic [1:0] STAT_MSB_LANE = 2'h3;

  localparam int B_FRESH = 0;
  localparam int B_FRESH_MISS = 1;
  localparam int B_MOVE = 2;
  localparam int B_MOVE_MISS = 3;
  localparam int B_LOCKED = 4;
  localparam int B_LOCKED_MISS = 5;
  localparam int B_EXPIRY = 6;
  localparam int B_EXPIRY_MISS = 7;
  localparam int B_STAT = 8;
  localparam int B_TEST = 9;

  localparam logic [FLAG_W-1:0] FLAGS_RST = 10'h000;
  localparam logic [FLAG_W-1:0] MASK_RST = 10'h000;
  localparam logic [7:0] RDATA_RST = 8'h00;

  typedef enum logic [1:0] {
    LRN_FRESH,
    LRN_MOVE,
    LRN_LOCKED
  } tev_kind_e;

  typedef struct packed {
    logic [MAC_W-1:0] mac;
    logic [PORT_W-1:0] port;
  } tev_entry_s;

  typedef struct packed {
    logic valid;
    tev_kind_e kind;
    tev_entry_s entry;
  } tev_learn_s;

  typedef struct packed {
    logic valid;
    tev_entry_s entry;
  } tev_expire_s;
endpackage

// >>> testbench/tev_event_report_bench.sv
`timescale 1ns/1ps
module tev_event_report_bench;
  logic clk, rst, rd_stb, wr_stb, rd_valid, irq;
  logic [7:0] addr, wdata, rdata, stat_msb, stat_clr;
  tev_pkg::tev_learn_s lrn;
  tev_pkg::tev_expire_s exq;
  tev_pkg::tev_entry_s cap [2];
  int err_count, checks_done, cyc, flags;
  int lock [2];
  logic [15:0] lf;

  tev_event_report dut (.CLK(clk), .RST(rst), .LRN_EVT(lrn),
    .EXP_EVT(exq), .STAT_MSB(stat_msb), .RD_STB(rd_stb),
    .WR_STB(wr_stb), .ADDR(addr), .WDATA(wdata), .RDATA(rdata),
    .RD_VALID(rd_valid), .HOST_IRQ_OUT(irq), .STAT_CLR(stat_clr));
  tev_host_model host (.CLK(clk), .RD_VALID(rd_valid), .RDATA(rdata),
    .RD_STB(rd_stb), .WR_STB(wr_stb), .ADDR(addr), .WDATA(wdata));

  task automatic rnd(output logic [7:0] v);
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    v = lf[7:0];
  endtask

  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic ok;
    host.acc(1'b0, a, 8'h00, q, ok);
    chk(ok === 1'b1 && q === e, $sformatf("read %h got %h", a, q));
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic ok;
    host.acc(1'b1, a, d, q, ok);
  endtask

  // Reference model: capture when free, else only the missed bit
  task automatic ev(input int k, input tev_pkg::tev_entry_s e);
    int g;
    g = (k == 3);
    @(negedge clk);
    if (k == 3) begin
      exq.valid = 1'b1;
      exq.entry = e;
    end else begin
      lrn.valid = 1'b1;
      lrn.kind = tev_pkg::tev_kind_e'(k);
      lrn.entry = e;
    end
    if (lock[g] == 0) begin
      flags |= 1 << (2 * k);
      cap[g] = e;
      lock[g] = 1;
    end else begin
      flags |= 2 << (2 * k);
    end
  endtask

  task automatic dump(input int g);
    logic [7:0] b, e;
    b = g ? tev_pkg::EXP_WORD0_OFS : tev_pkg::LRN_WORD0_OFS;
    for (int j = 0; j < 8; j++) begin
      e = 8'h00;
      if (j < 6)
        e = cap[g].mac[47 - 8 * j -: 8];
      else if (j == (g ? 6 : 7))
        e = cap[g].port;
      rd(b + 8'(j), e);
    end
    lock[g] = 0;
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Whole run is about 120 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      summarize();
    end
  end

  initial begin
    tev_pkg::tev_entry_s e1, e2;
    logic [7:0] i;
    rst = 1'b1;
    lrn = '0;
    exq = '0;
    stat_msb = 8'h00;
    lf = 16'h0029;
    flags = 0;
    lock = '{0, 0};
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rd(tev_pkg::INT_LO_OFS, 8'h00);
    wr(tev_pkg::MASK_LO_OFS, 8'hFF);
    wr(tev_pkg::MASK_HI_OFS, 8'h03);
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 7; j++) begin
        rnd(e1[8 * j +: 8]);
        rnd(e2[8 * j +: 8]);
      end
      ev(k, e1);
      ev(k, e2);
      @(negedge clk);
      lrn.valid = 1'b0;
      exq.valid = 1'b0;
      chk(irq === 1'b1, "irq after event");
      rd(tev_pkg::INT_LO_OFS, 8'(flags));
      flags &= 32'h300;
      chk(irq === 1'b0, "irq after clear");
      dump(k == 3);
      $display("event kind %0d done", k);
    end
    rnd(i);
    i = {5'h00, i[2:0]};
    @(negedge clk);
    stat_msb = 8'h01 << i;
    rd(tev_pkg::INT_HI_OFS, 8'h01);
    rd(tev_pkg::STAT_BASE_OFS + 8'(4 * i), 8'h00);
    rd(tev_pkg::STAT_BASE_OFS + 8'(4 * i + 3), 8'h00);
    chk(stat_clr === (8'h01 << i), "counter clear");
    rd(tev_pkg::STAT_BASE_OFS + 8'(tev_pkg::STAT_MSB_LANE), 8'h00);
    chk(stat_clr === 8'h01, "counter 0 clear");
    stat_msb = 8'h00;
    $display("statistic done");
    wr(tev_pkg::MASK_HI_OFS, 8'h00);
    wr(tev_pkg::INT_HI_OFS, 8'h02);
    chk(irq === 1'b0, "masked test flag");
    wr(tev_pkg::MASK_HI_OFS, 8'h02);
    chk(irq === 1'b1, "unmasked test flag");
    rd(tev_pkg::INT_HI_OFS, 8'h02);
    chk(irq === 1'b0, "test flag cleared");
    $display("test flag done");
    summarize();
  end
endmodule

// >>> testbench/tev_host_model.sv
`timescale 1ns/1ps
module tev_host_model (
  input wire logic CLK,
  input wire logic RD_VALID,
  input wire logic [7:0] RDATA,
  output logic RD_STB,
  output logic WR_STB,
  output logic [7:0] ADDR,
  output logic [7:0] WDATA
);
  initial begin
    RD_STB = 1'b0;
    WR_STB = 1'b0;
    ADDR = 8'h00;
    WDATA = 8'h00;
  end

  // One byte access; idle lines show the inverse so stale data never matches
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q,
                     output logic ok);
    @(negedge CLK);
    RD_STB = ~w;
    WR_STB = w;
    ADDR = a;
    WDATA = d;
    @(negedge CLK);
    RD_STB = 1'b0;
    WR_STB = 1'b0;
    ADDR = ~a;
    WDATA = ~d;
    q = RDATA;
    ok = (RD_VALID === ~w);
  endtask
endmodule
